// File: freq_word_upper_reg.sv
// Output gate and upper frequency offset word register with link access
`timescale 1ns/1ps
module freq_word_upper_reg
    import freq_word_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic reg_busy,
    output logic reg_rvalid,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [LOWER_W-1:0] freq_word_lower,
    input wire logic freq_word_lower_stb,
    input wire logic [RANGE_W-1:0] pull_range,
    input wire logic oe_sw_mode,
    input wire logic oe_pin,
    output logic signed [WORD_W-1:0] frequency_offset_word,
    output logic freq_update,
    output logic signed [SCALED_W-1:0] offset_scaled,
    output logic out_enable
);
    reg_xfer_if x ();

    logic req_s1_ff;
    logic req_s2_ff;
    logic req_s3_ff;
    logic ack_tgl_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [UPPER_W-1:0] upper_ff;
    logic oe_bit_ff;
    logic [LOWER_W-1:0] lower_shadow_ff;
    logic signed [WORD_W-1:0] word_ff;
    logic update_ff;
    logic signed [SCALED_W-1:0] scaled_ff;
    logic oe_s1_ff;
    logic oe_s2_ff;
    logic out_en_ff;
    logic req_evt;
    logic hit;
    logic upper_wr;
    logic [DATA_W-1:0] read_val;
    logic signed [HALF_W:0] half_s;

    reg_link_port link_port (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .reg_req(reg_req),
        .reg_we(reg_we),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_busy(reg_busy),
        .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata),
        .x(x.link_end)
    );

    // --------------------------------------------------------------
    // Request crossing into mclk
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
        end else begin
            req_s1_ff <= x.req_tgl;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
        end
    end

    // Fields are stable for the whole toggle round trip
    assign req_evt = req_s2_ff ^ req_s3_ff;
    assign hit = (x.addr == UPPER_REG_ADDR);
    assign upper_wr = req_evt & x.we & hit;

    // Unused upper bits are tied to zero on read
    always_comb begin
        read_val = UNMAPPED_READ;
        if (hit) begin
            read_val = {DATA_W{1'b0}};
            read_val[UPPER_W-1:0] = upper_ff;
            read_val[OE_BIT] = oe_bit_ff;
        end
    end

    // --------------------------------------------------------------
    // Answer back to the link side
    // --------------------------------------------------------------
    // Reads return the value after any write of the same access
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_tgl_ff <= 1'b0;
            rdata_ff <= '0;
        end else if (req_evt) begin
            ack_tgl_ff <= ~ack_tgl_ff;
            rdata_ff <= read_val;
            if (upper_wr) begin
                rdata_ff[UPPER_W-1:0] <= x.wdata[UPPER_W-1:0];
                if (oe_sw_mode) begin
                    rdata_ff[OE_BIT] <= x.wdata[OE_BIT];
                end
            end
        end
    end

    assign x.ack_tgl = ack_tgl_ff;
    assign x.rdata = rdata_ff;

    // --------------------------------------------------------------
    // Register fields
    // --------------------------------------------------------------
    // Bits 15:11 of a write are simply dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            upper_ff <= UPPER_RESET;
        end else if (upper_wr) begin
            upper_ff <= x.wdata[UPPER_W-1:0];
        end
    end

    // In pin mode the stored bit is left alone so software sees no effect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            oe_bit_ff <= OE_RESET;
        end else if (upper_wr && oe_sw_mode) begin
            oe_bit_ff <= x.wdata[OE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_shadow_ff <= LOWER_RESET;
        end else if (freq_word_lower_stb) begin
            lower_shadow_ff <= freq_word_lower;
        end
    end

    // --------------------------------------------------------------
    // Offset word apply
    // --------------------------------------------------------------
    // A lower write alone never moves the word; the host orders them
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            word_ff <= '0;
            update_ff <= 1'b0;
        end else begin
            update_ff <= upper_wr;
            if (upper_wr) begin
                word_ff <= {x.wdata[UPPER_W-1:0], lower_shadow_ff};
            end
        end
    end

    // Signed numerator; divide by 2^25-1 and 100 for ppm downstream
    assign half_s = signed'({1'b0, half_range(pull_range)});

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scaled_ff <= '0;
        end else begin
            scaled_ff <= word_ff * half_s;
        end
    end

    // --------------------------------------------------------------
    // Output enable
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            oe_s1_ff <= 1'b0;
            oe_s2_ff <= 1'b0;
            out_en_ff <= 1'b0;
        end else begin
            oe_s1_ff <= oe_pin;
            oe_s2_ff <= oe_s1_ff;
            out_en_ff <= oe_sw_mode ? oe_bit_ff : oe_s2_ff;
        end
    end

    assign frequency_offset_word = word_ff;
    assign freq_update = update_ff;
    assign offset_scaled = scaled_ff;
    assign out_enable = out_en_ff;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_unused_read_zero: assert property (
        req_evt |=> rdata_ff[UNUSED_MSB:UNUSED_LSB] == 5'h00)
        else $error("unused bits read nonzero");
    a_oe_sw_write: assert property (
        upper_wr && oe_sw_mode |=> oe_bit_ff == $past(x.wdata[OE_BIT])
            ##2 out_enable == $past(oe_bit_ff, 2))
        else $error("software enable not applied");
    a_oe_pin_ignores: assert property (
        upper_wr && !oe_sw_mode |=> $stable(oe_bit_ff))
        else $error("enable bit changed in pin mode");
    a_word_compose: assert property (
        upper_wr |=> word_ff == {$past(x.wdata[UPPER_W-1:0]),
            $past(lower_shadow_ff)})
        else $error("offset word not composed");
    // Own disable overrides the default one, which would hide the reset
    a_reset_nominal: assert property (@(posedge mclk)
        disable iff (1'b0)
        !rst_n |=> word_ff == '0 && !oe_bit_ff && !update_ff)
        else $error("reset state wrong");
    a_lower_no_apply: assert property (
        !upper_wr |=> $stable(word_ff) && !update_ff)
        else $error("word changed without upper write");
    a_update_pulse: assert property (
        upper_wr |=> update_ff ##1 !update_ff || $past(upper_wr))
        else $error("update pulse wrong");
    a_scale_sign: assert property (
        $past(word_ff) < 0 |-> scaled_ff < 0)
        else $error("negative word scaled non-negative");

    c_upper_write: cover property (upper_wr && oe_sw_mode);
    c_lower_then_upper: cover property (
        freq_word_lower_stb ##[1:50] upper_wr);
    c_negative_word: cover property (update_ff && word_ff < 0);
endmodule : freq_word_upper_reg

// File: freq_word_pkg.sv
// Constants and lookup for the frequency offset word upper register
package freq_word_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int UPPER_W = 10;
    localparam int LOWER_W = 16;
    localparam int WORD_W = 26;
    localparam int RANGE_W = 4;
    localparam int HALF_W = 20;
    localparam int SCALED_W = 47;
    localparam int OE_BIT = 10;
    localparam int UNUSED_LSB = 11;
    localparam int UNUSED_MSB = 15;
    localparam logic [ADDR_W-1:0] UPPER_REG_ADDR = 8'h01;
    localparam logic [UPPER_W-1:0] UPPER_RESET = 10'h000;
    localparam logic [LOWER_W-1:0] LOWER_RESET = 16'h0000;
    localparam logic OE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

    // Half pull range in units of 0.01 ppm, indexed by pull-range code
    function automatic logic [HALF_W-1:0] half_range(
        input logic [RANGE_W-1:0] code
    );
        logic [HALF_W-1:0] r;
        r = 20'h00000;
        unique case (code)
            4'h0: r = 20'h00271;
            4'h1: r = 20'h003e8;
            4'h2: r = 20'h004e2;
            4'h3: r = 20'h009c4;
            4'h4: r = 20'h01388;
            4'h5: r = 20'h01f40;
            4'h6: r = 20'h02710;
            4'h7: r = 20'h030d4;
            4'h8: r = 20'h03a98;
            4'h9: r = 20'h04e20;
            4'ha: r = 20'h09c40;
            4'hb: r = 20'h0ea60;
            4'hc: r = 20'h13880;
            4'hd: r = 20'h1d4c0;
            4'he: r = 20'h27100;
            4'hf: r = 20'h4e200;
        endcase
        return r;
    endfunction : half_range
endpackage : freq_word_pkg

// File: reg_xfer_if.sv
// Crossing carrier between the link-side port and the register core
`timescale 1ns/1ps
interface reg_xfer_if;
    import freq_word_pkg::*;
    logic req_tgl;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack_tgl;
    logic [DATA_W-1:0] rdata;

    modport link_end (
        output req_tgl,
        output we,
        output addr,
        output wdata,
        input ack_tgl,
        input rdata
    );
    modport core_end (
        input req_tgl,
        input we,
        input addr,
        input wdata,
        output ack_tgl,
        output rdata
    );
endinterface : reg_xfer_if

// File: reg_link_port.sv
// Link-clock side of the register access handshake
`timescale 1ns/1ps
module reg_link_port
    import freq_word_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic reg_busy,
    output logic reg_rvalid,
    output logic [DATA_W-1:0] reg_rdata,
    reg_xfer_if.link_end x
);
    logic req_tgl_ff;
    logic we_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic ack_s3_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic take;

    // Busy until the core's acknowledge has come back across
    assign reg_busy = req_tgl_ff ^ ack_s3_ff;
    assign take = reg_req & ~reg_busy;

    // --------------------------------------------------------------
    // Request launch
    // --------------------------------------------------------------
    // Fields are frozen while busy, so the core may sample them late
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            req_tgl_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
        end else if (take) begin
            req_tgl_ff <= ~req_tgl_ff;
            we_ff <= reg_we;
            addr_ff <= reg_addr;
            wdata_ff <= reg_wdata;
        end
    end

    // --------------------------------------------------------------
    // Acknowledge return
    // --------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            ack_s3_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_s1_ff <= x.ack_tgl;
            ack_s2_ff <= ack_s1_ff;
            ack_s3_ff <= ack_s2_ff;
            rvalid_ff <= ack_s2_ff ^ ack_s3_ff;
            if (ack_s2_ff ^ ack_s3_ff) begin
                rdata_ff <= x.rdata;
            end
        end
    end

    assign x.req_tgl = req_tgl_ff;
    assign x.we = we_ff;
    assign x.addr = addr_ff;
    assign x.wdata = wdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign reg_rdata = rdata_ff;

    a_busy_after_take: assert property (@(posedge link_clk)
        disable iff (!link_rst_n) take |=> reg_busy)
        else $error("busy not raised after request taken");
    a_answer_bounded: assert property (@(posedge link_clk)
        disable iff (!link_rst_n) take |-> ##[3:20] reg_rvalid)
        else $error("no answer within bound");
    c_access_done: cover property (@(posedge link_clk)
        disable iff (!link_rst_n) take ##[3:20] reg_rvalid);
endmodule : reg_link_port

// File: host_link_model.sv
// Link-side host model issuing accesses to the register
`timescale 1ns/1ps
module host_link_model
    import freq_word_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_rst_n,
    output logic reg_req,
    output logic reg_we,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_busy,
    input wire logic reg_rvalid,
    input wire logic [DATA_W-1:0] reg_rdata
);
    // One update period at 38 kHz, in ns
    localparam real UPD_GAP = 26316.0;
    real last_upd = -1.0e9;

    initial begin
        reg_req = 1'b0;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end

    // Stands in for the two-wire engine: one access at a time
    task automatic access(input logic we, input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] wdata, input int gap,
                          output logic [DATA_W-1:0] rdata, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 16'h0000;
        if (we && addr == UPPER_REG_ADDR) begin
            while ($realtime - last_upd < UPD_GAP) @(negedge link_clk);
        end
        repeat (gap) @(negedge link_clk);
        while (reg_busy === 1'b1 && n < 40) begin
            @(negedge link_clk);
            n++;
        end
        reg_req = 1'b1;
        reg_we = we;
        reg_addr = addr;
        reg_wdata = wdata;
        // Released while the answer pulse stands, so no second take
        n = 0;
        while (n < 40 && !ok) begin
            @(negedge link_clk);
            n++;
            if (reg_rvalid === 1'b1) begin
                rdata = reg_rdata;
                ok = 1'b1;
            end
        end
        reg_req = 1'b0;
        reg_we = ~we;
        reg_addr = ~addr;
        reg_wdata = ~wdata;
        if (ok && we && addr == UPPER_REG_ADDR) last_upd = $realtime;
    endtask : access
endmodule : host_link_model

// File: test_freq_word_upper_and_oe_reg.sv
// Self-checking testbench of the upper word and output gate register
`timescale 1ns/1ps
module test_freq_word_upper_and_oe_reg;
    import freq_word_pkg::*;
    logic mclk, rst_n, link_clk, link_rst_n;
    logic reg_req, reg_we, reg_busy, reg_rvalid;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [LOWER_W-1:0] freq_word_lower;
    logic freq_word_lower_stb, oe_sw_mode, oe_pin, freq_update, out_enable;
    logic [RANGE_W-1:0] pull_range;
    logic signed [WORD_W-1:0] frequency_offset_word;
    logic signed [SCALED_W-1:0] offset_scaled;
    int failures = 0;
    int checked = 0;
    int updates = 0;

    freq_word_upper_reg dut (.mclk(mclk), .rst_n(rst_n),
        .link_clk(link_clk), .link_rst_n(link_rst_n), .reg_req(reg_req),
        .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_busy(reg_busy), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .freq_word_lower(freq_word_lower),
        .freq_word_lower_stb(freq_word_lower_stb), .pull_range(pull_range),
        .oe_sw_mode(oe_sw_mode), .oe_pin(oe_pin),
        .frequency_offset_word(frequency_offset_word),
        .freq_update(freq_update), .offset_scaled(offset_scaled),
        .out_enable(out_enable));

    host_link_model host (.link_clk(link_clk), .link_rst_n(link_rst_n),
        .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Link clock offset so its edges never line up with mclk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    always @(posedge mclk) begin
        if (freq_update === 1'b1) updates <= updates + 1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [63:0] got,
                         input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        logic [15:0] r;
        bit ok;
        host.access(1'b1, addr, data, 1, r, ok);
        check("write_answer", 64'(ok), 64'h1);
        repeat (4) @(negedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] r;
        bit ok;
        host.access(1'b0, addr, 16'h0000, 3, r, ok);
        check("read_answer", 64'(ok), 64'h1);
        check("read_data", 64'(r), 64'(exp));
        check("busy_idle", 64'(reg_busy), 64'h0);
    endtask : rd

    task automatic load_lower(input logic [15:0] v);
        @(negedge mclk);
        freq_word_lower = v;
        freq_word_lower_stb = 1'b1;
        @(negedge mclk);
        freq_word_lower_stb = 1'b0;
        repeat (8) @(negedge mclk);
    endtask : load_lower

    task automatic results;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        link_rst_n = 1'b0;
        freq_word_lower = 16'h0000;
        freq_word_lower_stb = 1'b0;
        pull_range = 4'h9;
        oe_sw_mode = 1'b1;
        oe_pin = 1'b0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge link_clk);
        link_rst_n = 1'b1;
        rd(UPPER_REG_ADDR, 16'h0000);
        check("word", 64'(frequency_offset_word), 64'h0);
        check("oe", 64'(out_enable), 64'h0);
        $display("test reset values done");
        // Host loads the lower word first
        load_lower(16'h1234);
        check("word", 64'(frequency_offset_word), 64'h0);
        check("updates", 64'(updates), 64'h0);
        wr(UPPER_REG_ADDR, 16'hffff);
        // Zero-extended so the raw 26-bit pattern is compared
        check("word", 64'($unsigned(frequency_offset_word)),
              64'h3ff1234);
        check("updates", 64'(updates), 64'h1);
        check("scaled", 64'(offset_scaled),
              64'(-47'sd1217520000));
        check("oe", 64'(out_enable), 64'h1);
        rd(UPPER_REG_ADDR, 16'h07ff);
        $display("test negative word done");
        load_lower(16'hffff);
        wr(UPPER_REG_ADDR, 16'h01ff);
        check("word", 64'(frequency_offset_word), 64'h1ffffff);
        check("scaled", 64'(offset_scaled),
              64'(47'sd671088620000));
        check("oe", 64'(out_enable), 64'h0);
        pull_range = 4'hf;
        repeat (2) @(negedge mclk);
        check("scaled", 64'(offset_scaled),
              64'(47'sd10737417920000));
        $display("test full scale done");
        oe_sw_mode = 1'b0;
        wr(UPPER_REG_ADDR, 16'h0400);
        check("oe", 64'(out_enable), 64'h0);
        check("word", 64'(frequency_offset_word), 64'h000ffff);
        rd(UPPER_REG_ADDR, 16'h0000);
        oe_pin = 1'b1;
        repeat (6) @(negedge mclk);
        check("oe", 64'(out_enable), 64'h1);
        $display("test pin mode done");
        wr(8'h02, 16'h5a5a);
        rd(8'h02, 16'h0000);
        check("updates", 64'(updates), 64'h3);
        check("word", 64'(frequency_offset_word), 64'h000ffff);
        $display("test unmapped done");
        results();
    end

    initial begin
        #300000;
        failures++;
        $display("watchdog expired");
        results();
    end
endmodule : test_freq_word_upper_and_oe_reg
